// [logic/ccdc_defines.vh]
// Purpose: Shared constants of the charge/discharge counter block
// Assumes: 250 MHz system clock, 4 ns period
// Notes: Byte offsets are the full APB byte addresses
`ifndef CCDC_DEFINES_VH
`define CCDC_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CCDC_OFF_MODE      8'h00
`define CCDC_OFF_CLEAR     8'h04
`define CCDC_OFF_OFFSET    8'h08
`define CCDC_OFF_DCHG_CNT  8'h0C
`define CCDC_OFF_CHG_CNT   8'h10
`define CCDC_OFF_SELF_CNT  8'h14
`define CCDC_OFF_DCHG_TIME 8'h18
`define CCDC_OFF_CHG_TIME  8'h1C
`define CCDC_OFF_COMMAND   8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define CCDC_MODE_REGDIS   0
`define CCDC_MODE_CHG_SLOW 1
`define CCDC_MODE_DCH_SLOW 2
`define CCDC_CLR_DCHG_CNT  0
`define CCDC_CLR_CHG_CNT   1
`define CCDC_CLR_SELF_CNT  2
`define CCDC_CLR_DCHG_TIME 3
`define CCDC_CLR_CHG_TIME  4
`define CCDC_OFS_CAL_OK    20
`define CCDC_OFS_COMP_EN   21
`define CCDC_OFS_DIR_CHG   22
`define CCDC_CMD_SLEEP     0
`define CCDC_CMD_HW_RESET  1
`define CCDC_CMD_FLASH_PGM 2
`define CCDC_CMD_FLASH_RCL 3

// ****************************************************************
// Reset values
// ****************************************************************
`define CCDC_RST_OFFSET    20'h00000
`define CCDC_RST_COUNT     16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define CCDC_CLK_PERIOD_NS 4
`define CCDC_TICK_TIME_NS  878900000
`define CCDC_STEP_TIME_NS  9760000
`define CCDC_TICK_CYCLES   (`CCDC_TICK_TIME_NS / `CCDC_CLK_PERIOD_NS)
`define CCDC_STEP_CYCLES   (`CCDC_STEP_TIME_NS / `CCDC_CLK_PERIOD_NS)
`define CCDC_SLOW_DIV      256

`endif

// [logic/ccdc_time_counter.v]
// Purpose: One 16-bit activity time counter with rollover slow-down
// Assumes: Ticks are one-cycle enables from the shared divider
// Notes: Clear zeroes both count and slow flag
`timescale 1ns/1ns

module ccdc_time_counter #(
  parameter WIDTH = 16
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_tick,
  input wire i_slow_tick,
  input wire i_active,
  input wire i_clear,
  output reg [WIDTH-1:0] o_count,
  output reg o_slow
);

  // Count enable picks the normal or the 1/256 rate
  wire step_en;
  assign step_en = i_active & (o_slow ? i_slow_tick : i_tick);

  // ****************************************************************
  // Counter and rollover flag
  // ****************************************************************
  // Clear has priority so software sees a clean zero after it
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_count <= {WIDTH{1'b0}};
      o_slow <= 1'b0;
    end
    else if (i_clear)
    begin
      // Also restores the default rate
      o_count <= {WIDTH{1'b0}};
      o_slow <= 1'b0;
    end
    else if (step_en)
    begin
      // Natural wrap past the top value
      o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
      if (&o_count)
      begin
        o_slow <= 1'b1;
      end
    end
  end

endmodule // ccdc_time_counter

// [logic/ccdc_top.v]
// Purpose: Coulomb counting core with APB register access
// Assumes: VOLTAGE_TO_FREQUENCY_CONVERTER pulses and polarity levels are synchronous to i_clk_sys
// Notes: Calibration and flash engines sit outside; sleep and flash commands leave as pulses, hardware reset stays inside
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "ccdc_defines.vh"

module ccdc_top #(
  parameter TICK_CYC = `CCDC_TICK_CYCLES,
  parameter STEP_CYC = `CCDC_STEP_CYCLES,
  parameter CW = 16
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_vfc_pulse,
  input wire i_sense_pos,
  input wire i_sense_neg,
  input wire signed [7:0] i_die_temp,
  input wire i_calib_ok,
  output reg o_reg_amp_en,
  output reg o_cmd_sleep,
  output reg o_cmd_flash_pgm,
  output reg o_cmd_flash_rcl
);

  // ****************************************************************
  // Widths of the dividers
  // ****************************************************************
  localparam [31:0] TICK_LAST_W = TICK_CYC - 1;
  localparam [31:0] STEP_LAST_W = STEP_CYC - 1;
  localparam [31:0] SLOW_LAST_W = `CCDC_SLOW_DIV - 1;
  localparam [27:0] TICK_LAST = TICK_LAST_W[27:0];
  localparam [21:0] STEP_LAST = STEP_LAST_W[21:0];
  localparam [7:0] SLOW_LAST = SLOW_LAST_W[7:0];

  // ****************************************************************
  // State declarations
  // ****************************************************************
  reg [27:0] tick_cnt_r; // Base timebase divider
  reg [7:0] slow_cnt_r; // Divides base ticks by 256
  reg tick_r; // Pulse every 0.8789 s
  reg slow_tick_r; // Pulse every 225 s, also hour/16
  reg [7:0] self_acc_r; // Fractional self-discharge accumulator
  reg [CW-1:0] dchg_cnt_r; // Discharge count
  reg [CW-1:0] chg_cnt_r; // Charge count
  reg [CW-1:0] self_cnt_r; // Self-discharge count
  reg regdis_r; // Regulator disable
  reg [4:0] clr_r; // Pending clear bits
  reg [19:0] offset_r; // Flash-shadowed offset value
  reg comp_en_r; // Offset compensation enable
  reg dir_chg_r; // 1 adds to charge, 0 to discharge
  reg [21:0] step_cnt_r; // 9.76 ms step divider
  reg [19:0] ival_cnt_r; // Steps elapsed in current interval
  reg comp_hit_r; // One-cycle compensation count
  reg hw_reset_r; // Register reset command pulse
  reg [31:0] rdata_nxt; // Read mux output
  reg rd_err_nxt; // Unmapped address

  wire [CW-1:0] dchg_time;
  wire [CW-1:0] chg_time;
  wire dchg_slow;
  wire chg_slow;

  // ****************************************************************
  // APB access decode
  // ****************************************************************
  // Access completes on the second penable cycle, pready from a flop
  wire acc_done;
  wire wr_en;
  assign acc_done = i_psel & i_penable & o_pready;
  assign wr_en = acc_done & i_pwrite;

  // Sense polarity; zero voltage means both levels or neither level is set
  wire dischg;
  wire chg;
  assign dischg = i_sense_neg & ~i_sense_pos;
  assign chg = i_sense_pos & ~i_sense_neg;

  // Compensation only counts after a good calibration
  wire comp_run;
  assign comp_run = comp_en_r & i_calib_ok;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  // One divider feeds the time counters and self-discharge so their rates stay locked together
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_r <= 28'h0000000;
      slow_cnt_r <= 8'h00;
      tick_r <= 1'b0;
      slow_tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= 1'b0;
      slow_tick_r <= 1'b0;
      if (tick_cnt_r == TICK_LAST)
      begin
        // Base period of 0.8789 s
        tick_cnt_r <= 28'h0000000;
        tick_r <= 1'b1;
        slow_cnt_r <= slow_cnt_r + 8'h01;
        if (slow_cnt_r == SLOW_LAST)
        begin
          slow_tick_r <= 1'b1;
        end
      end
      else
      begin
        tick_cnt_r <= tick_cnt_r + 28'h0000001;
      end
    end
  end

  // ****************************************************************
  // Time counters
  // ****************************************************************
  // Discharge time runs only while discharging
  ccdc_time_counter #(
    .WIDTH(CW)
  ) u_dchg_time (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_tick(tick_r),
    .i_slow_tick(slow_tick_r),
    .i_active(dischg),
    .i_clear(clr_r[`CCDC_CLR_DCHG_TIME] | hw_reset_r),
    .o_count(dchg_time),
    .o_slow(dchg_slow)
  );

  // Charge time runs only while charging
  ccdc_time_counter #(
    .WIDTH(CW)
  ) u_chg_time (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_tick(tick_r),
    .i_slow_tick(slow_tick_r),
    .i_active(chg),
    .i_clear(clr_r[`CCDC_CLR_CHG_TIME] | hw_reset_r),
    .o_count(chg_time),
    .o_slow(chg_slow)
  );

  // ****************************************************************
  // Self-discharge temperature weight
  // ****************************************************************
  // Weight 16 per hour/16 makes one count an hour at 25C;
  // bands are 10C wide and clamp below 5C and from 55C up
  function [7:0] self_weight;
    input signed [7:0] temp;
    begin
      if (temp >= 8'sd55)
        self_weight = 8'h80;
      else if (temp >= 8'sd45)
        self_weight = 8'h40;
      else if (temp >= 8'sd35)
        self_weight = 8'h20;
      else if (temp >= 8'sd25)
        self_weight = 8'h10;
      else if (temp >= 8'sd15)
        self_weight = 8'h08;
      else if (temp >= 8'sd5)
        self_weight = 8'h04;
      else
        self_weight = 8'h02;
    end
  endfunction

  wire [8:0] self_sum;
  assign self_sum = {1'b0, self_acc_r} + {1'b0, self_weight(i_die_temp)};

  // ****************************************************************
  // Offset compensation timer
  // ****************************************************************
  // A zero offset never fires, which avoids a count every step
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      step_cnt_r <= 22'h000000;
      ival_cnt_r <= 20'h00000;
      comp_hit_r <= 1'b0;
    end
    else if (!comp_run || offset_r == 20'h00000)
    begin
      // Idle: restart the interval when enabled again
      step_cnt_r <= 22'h000000;
      ival_cnt_r <= 20'h00000;
      comp_hit_r <= 1'b0;
    end
    else
    begin
      comp_hit_r <= 1'b0;
      if (step_cnt_r == STEP_LAST)
      begin
        // One 9.76 ms step elapsed
        step_cnt_r <= 22'h000000;
        if (ival_cnt_r + 20'h00001 >= offset_r)
        begin
          ival_cnt_r <= 20'h00000;
          comp_hit_r <= 1'b1;
        end
        else
        begin
          ival_cnt_r <= ival_cnt_r + 20'h00001;
        end
      end
      else
      begin
        step_cnt_r <= step_cnt_r + 22'h000001;
      end
    end
  end

  // Per-cycle increments; a VOLTAGE_TO_FREQUENCY_CONVERTER pulse and a compensation count may coincide
  wire [CW-1:0] dchg_inc;
  wire [CW-1:0] chg_inc;
  assign dchg_inc = {{(CW-1){1'b0}}, i_vfc_pulse & dischg}
                  + {{(CW-1){1'b0}}, comp_hit_r & ~dir_chg_r};
  assign chg_inc = {{(CW-1){1'b0}}, i_vfc_pulse & chg}
                 + {{(CW-1){1'b0}}, comp_hit_r & dir_chg_r};

  // ****************************************************************
  // Count registers
  // ****************************************************************
  // Clear wins over counting; all wrap silently
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      dchg_cnt_r <= `CCDC_RST_COUNT;
      chg_cnt_r <= `CCDC_RST_COUNT;
      self_cnt_r <= `CCDC_RST_COUNT;
      self_acc_r <= 8'h00;
    end
    else
    begin
      // Discharge count
      if (clr_r[`CCDC_CLR_DCHG_CNT] | hw_reset_r)
        dchg_cnt_r <= `CCDC_RST_COUNT;
      else
        dchg_cnt_r <= dchg_cnt_r + dchg_inc;
      // Charge count
      if (clr_r[`CCDC_CLR_CHG_CNT] | hw_reset_r)
        chg_cnt_r <= `CCDC_RST_COUNT;
      else
        chg_cnt_r <= chg_cnt_r + chg_inc;
      // Self-discharge keeps going at zero current
      if (clr_r[`CCDC_CLR_SELF_CNT] | hw_reset_r)
      begin
        self_cnt_r <= `CCDC_RST_COUNT;
        self_acc_r <= 8'h00;
      end
      else if (slow_tick_r)
      begin
        self_acc_r <= self_sum[7:0];
        if (self_sum[8])
          self_cnt_r <= self_cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************************************
  // Control registers and commands
  // ****************************************************************
  // Clear bits: software set wins over the hardware self-clear
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      regdis_r <= 1'b0;
      clr_r <= 5'h00;
      offset_r <= `CCDC_RST_OFFSET;
      comp_en_r <= 1'b0;
      dir_chg_r <= 1'b0;
      hw_reset_r <= 1'b0;
      o_cmd_sleep <= 1'b0;
      o_cmd_flash_pgm <= 1'b0;
      o_cmd_flash_rcl <= 1'b0;
      o_reg_amp_en <= 1'b1;
    end
    else
    begin
      // Pending clears act for one cycle, then drop
      clr_r <= 5'h00;
      hw_reset_r <= 1'b0;
      o_cmd_sleep <= 1'b0;
      o_cmd_flash_pgm <= 1'b0;
      o_cmd_flash_rcl <= 1'b0;
      // Amplifier stays on in sleep unless disabled
      o_reg_amp_en <= ~regdis_r;
      if (hw_reset_r)
      begin
        regdis_r <= 1'b0;
      end
      if (wr_en)
      begin
        case (i_paddr)
          `CCDC_OFF_MODE:
            regdis_r <= i_pwdata[`CCDC_MODE_REGDIS];
          `CCDC_OFF_CLEAR:
            clr_r <= i_pwdata[4:0];
          `CCDC_OFF_OFFSET:
          begin
            offset_r <= i_pwdata[19:0];
            comp_en_r <= i_pwdata[`CCDC_OFS_COMP_EN];
            dir_chg_r <= i_pwdata[`CCDC_OFS_DIR_CHG];
          end
          `CCDC_OFF_COMMAND:
          begin
            // Each command bit becomes a one-cycle pulse
            o_cmd_sleep <= i_pwdata[`CCDC_CMD_SLEEP];
            hw_reset_r <= i_pwdata[`CCDC_CMD_HW_RESET];
            o_cmd_flash_pgm <= i_pwdata[`CCDC_CMD_FLASH_PGM];
            o_cmd_flash_rcl <= i_pwdata[`CCDC_CMD_FLASH_RCL];
          end
          default:
          begin
            // Unmapped or read-only: write dropped, error flagged only if unmapped
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Reserved bits read as zero
  always @*
  begin
    rdata_nxt = 32'h00000000;
    rd_err_nxt = 1'b0;
    case (i_paddr)
      `CCDC_OFF_MODE:
        rdata_nxt = {29'h0000000, dchg_slow, chg_slow, regdis_r};
      `CCDC_OFF_CLEAR:
        rdata_nxt = {27'h0000000, clr_r};
      `CCDC_OFF_OFFSET:
        rdata_nxt = {9'h000, dir_chg_r, comp_en_r, i_calib_ok, offset_r};
      `CCDC_OFF_DCHG_CNT:
        rdata_nxt = {16'h0000, dchg_cnt_r};
      `CCDC_OFF_CHG_CNT:
        rdata_nxt = {16'h0000, chg_cnt_r};
      `CCDC_OFF_SELF_CNT:
        rdata_nxt = {16'h0000, self_cnt_r};
      `CCDC_OFF_DCHG_TIME:
        rdata_nxt = {16'h0000, dchg_time};
      `CCDC_OFF_CHG_TIME:
        rdata_nxt = {16'h0000, chg_time};
      `CCDC_OFF_COMMAND:
        rdata_nxt = 32'h00000000;
      default:
        rd_err_nxt = 1'b1;
    endcase
  end

  // ****************************************************************
  // APB response
  // ****************************************************************
  // One wait state keeps every output a flop; data sampled in it
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else if (i_psel && i_penable && !o_pready)
    begin
      o_pready <= 1'b1;
      o_pslverr <= rd_err_nxt;
      o_prdata <= i_pwrite ? 32'h00000000 : rdata_nxt;
    end
    else
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
  end

endmodule // ccdc_top

// [tb/ccdc_top_props.sv]
// Purpose: Port-level checks of the charge/discharge counter
// Assumes: APB slave answers with one wait state
// Notes: Bound into every ccdc_top instance
`timescale 1ns/1ns
`include "ccdc_defines.vh"

module ccdc_top_props (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_reg_amp_en,
  input wire o_cmd_sleep,
  input wire o_cmd_flash_pgm,
  input wire o_cmd_flash_rcl
);
  // ****************************************************************
  // Bus and output checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // Completed write, seen at the edge that samples pready
  wire wr_done = i_psel && i_penable && i_pwrite && o_pready;
  // Completed write to the command register
  wire cmd_wr = wr_done && (i_paddr == `CCDC_OFF_COMMAND);

  pready_wait_a:
    assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready) else $error("pready not in 2nd cycle");
  pready_pulse_a:
    assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
  error_ready_a:
    assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
  unmapped_error_a:
    assert property (o_pready && i_paddr > 8'h20 |-> o_pslverr) else $error("unmapped access not refused");
  mapped_ok_a:
    assert property (o_pready && i_paddr[1:0] == 2'h0 && i_paddr <= 8'h20 |-> !o_pslverr) else $error("bad pslverr");
  rdata_quiet_a:
    assert property (!(o_pready && !i_pwrite) |-> o_prdata == 32'h0) else $error("prdata outside read answer");
  regulator_follow_a:
    assert property (wr_done && i_paddr == `CCDC_OFF_MODE |-> ##2 o_reg_amp_en == !$past(i_pwdata[0], 2))
      else $error("amplifier enable does not follow mode write");
  command_pulse_a:
    assert property (cmd_wr |=> {o_cmd_flash_rcl, o_cmd_flash_pgm, o_cmd_sleep} ==
      {$past(i_pwdata[3]), $past(i_pwdata[2]), $past(i_pwdata[0])}) else $error("command pulse mismatch");
  command_cause_a:
    assert property (o_cmd_sleep || o_cmd_flash_pgm || o_cmd_flash_rcl |-> $past(cmd_wr))
      else $error("command pulse without command write");
endmodule // ccdc_top_props

bind ccdc_top ccdc_top_props u_props (.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_prdata, .o_pready, .o_pslverr, .o_reg_amp_en, .o_cmd_sleep, .o_cmd_flash_pgm, .o_cmd_flash_rcl);

// [tb/ccdc_sense_model.sv]
// Purpose: Sense front end model, polarity levels and converter pulses
// Assumes: Pulses are one cycle wide, gaps of 0 to 2 idle cycles
// Notes: Polarity follows i_pol one cycle later
`timescale 1ns/1ns

module ccdc_sense_model (
  input wire i_clk_sys,
  input wire [1:0] i_pol,
  input wire i_start,
  input wire [7:0] i_count,
  output reg o_vfc_pulse,
  output reg o_sense_pos,
  output reg o_sense_neg,
  output reg o_busy
);
  reg [7:0] left_r = 8'h00; // Pulses still to send
  reg [1:0] gap_r = 2'h0; // Idle cycles before next pulse
  initial
  begin
    o_vfc_pulse = 1'b0;
    o_sense_pos = 1'b0;
    o_sense_neg = 1'b0;
    o_busy = 1'b0;
  end
  // Random gaps show the counters both dense and sparse pulse trains
  always @(posedge i_clk_sys)
  begin
    o_sense_pos <= i_pol[0];
    o_sense_neg <= i_pol[1];
    o_vfc_pulse <= 1'b0;
    if (i_start)
    begin
      left_r <= i_count;
      gap_r <= 2'h1;
      o_busy <= (i_count != 8'h00);
    end
    else if (left_r != 8'h00)
    begin
      if (gap_r == 2'h0)
      begin
        o_vfc_pulse <= 1'b1;
        left_r <= left_r - 8'h01;
        gap_r <= $urandom % 3;
      end
      else
        gap_r <= gap_r - 2'h1;
    end
    else
      o_busy <= 1'b0;
  end
endmodule // ccdc_sense_model

// [tb/ccdc_top_tb.sv]
// Purpose: Self-checking bench of the charge/discharge counter
// Assumes: Tick divider shortened to one cycle so a time counter wraps quickly
// Notes: Read results are checked by a monitor against a queue of notes
`timescale 1ns/1ns
`include "ccdc_defines.vh"

module ccdc_top_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n, i_psel, i_penable, i_pwrite, i_calib_ok, start;
  logic [7:0] i_paddr, cnt;
  logic [31:0] i_pwdata, n_d, n_c;
  logic signed [7:0] i_die_temp;
  logic [1:0] pol;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, i_vfc_pulse, i_sense_pos, i_sense_neg, busy;
  wire o_reg_amp_en, o_cmd_sleep, o_cmd_flash_pgm, o_cmd_flash_rcl;
  int failures = 0;
  int checks_done = 0;
  logic [32:0] expq[$]; // Expected {pslverr, prdata} per transfer

  ccdc_top #(.TICK_CYC(1), .STEP_CYC(4)) dut (.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_vfc_pulse, .i_sense_pos, .i_sense_neg, .i_die_temp,
    .i_calib_ok, .o_reg_amp_en, .o_cmd_sleep, .o_cmd_flash_pgm, .o_cmd_flash_rcl);
  ccdc_sense_model u_sense (.i_clk_sys, .i_pol(pol), .i_start(start), .i_count(cnt), .o_vfc_pulse(i_vfc_pulse),
    .o_sense_pos(i_sense_pos), .o_sense_neg(i_sense_neg), .o_busy(busy));

  // ****************************************************************
  // Clock, compare and closing
  // ****************************************************************
  initial
    forever #2 i_clk_sys = ~i_clk_sys;

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Monitor: every answer takes the oldest note
  always @(posedge i_clk_sys)
    if (o_pready === 1'b1)
    begin
      if (expq.size() == 0)
        chk({o_pslverr, o_prdata}, 33'h1FFFFFFFF);
      else
        chk({o_pslverr, o_prdata}, expq.pop_front());
    end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  // APB master: holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    expq.push_back(e);
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, {1'b0, e});
  endtask

  // Self-discharge weight per 256 base ticks: doubles per 10C band above 25C
  function automatic logic [31:0] sd_weight(input int t);
    return (t >= 55) ? 128 : (t >= 45) ? 64 : (t >= 35) ? 32 : (t >= 25) ? 16 :
      (t >= 15) ? 8 : (t >= 5) ? 4 : 2;
  endfunction

  // Polarity settles before the pulses and stays until they have landed
  task burst(input logic [1:0] p, input logic [7:0] n);
    pol <= p;
    repeat (2) @(posedge i_clk_sys);
    start <= 1'b1;
    cnt <= n;
    @(posedge i_clk_sys);
    start <= 1'b0;
    do @(posedge i_clk_sys); while (busy !== 1'b0);
    repeat (2) @(posedge i_clk_sys);
    pol <= 2'b00;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h00000000;
    i_calib_ok = 1'b0;
    i_die_temp = 8'sh19;
    pol = 2'b00;
    start = 1'b0;
    cnt = 8'h00;
    void'($urandom(32'h78020ebd));
    n_d = $urandom % 40 + 1;
    n_c = $urandom % 40 + 1;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    i_die_temp <= $urandom % 61;
    rd(`CCDC_OFF_MODE, 32'h00000000);
    apb(1'b0, 8'h24, 32'h00000000, 33'h100000000);
    // Compensation armed but calibration missing: counts must stay exact
    wr(`CCDC_OFF_OFFSET, 32'h00600005);
    rd(`CCDC_OFF_OFFSET, 32'h00600005);
    wr(`CCDC_OFF_CLEAR, 32'h0000001F);
    rd(`CCDC_OFF_CLEAR, 32'h00000000);
    burst(2'b10, n_d[7:0]);
    rd(`CCDC_OFF_DCHG_CNT, n_d);
    rd(`CCDC_OFF_CHG_CNT, 32'h00000000);
    burst(2'b01, n_c[7:0]);
    rd(`CCDC_OFF_CHG_CNT, n_c);
    rd(`CCDC_OFF_DCHG_CNT, n_d);
    // Zero voltage in both encodings
    burst(2'b11, 8'h09);
    burst(2'b00, 8'h07);
    rd(`CCDC_OFF_DCHG_CNT, n_d);
    rd(`CCDC_OFF_CHG_CNT, n_c);
    // Charge held for 100 base ticks advances the charge time by 100
    wr(`CCDC_OFF_CLEAR, 32'h00000010);
    pol <= 2'b01;
    repeat (100) @(posedge i_clk_sys);
    pol <= 2'b00;
    rd(`CCDC_OFF_CHG_TIME, 32'h00000064);
    wr(`CCDC_OFF_DCHG_CNT, 32'h0000FFFF);
    rd(`CCDC_OFF_DCHG_CNT, n_d);
    // Discharge held past 65536 ticks wraps the time counter
    // Window of 256 or 257 slow ticks gives exactly one weight of self counts
    wr(`CCDC_OFF_CLEAR, 32'h0000001C);
    pol <= 2'b10;
    repeat (65600) @(posedge i_clk_sys);
    pol <= 2'b00;
    rd(`CCDC_OFF_MODE, 32'h00000004);
    rd(`CCDC_OFF_SELF_CNT, sd_weight(i_die_temp));
    wr(`CCDC_OFF_CLEAR, 32'h00000008);
    rd(`CCDC_OFF_MODE, 32'h00000000);
    rd(`CCDC_OFF_DCHG_TIME, 32'h00000000);
    rd(`CCDC_OFF_CLEAR, 32'h00000000);
    wr(`CCDC_OFF_MODE, 32'h00000001);
    rd(`CCDC_OFF_MODE, 32'h00000001);
    chk({32'h00000000, o_reg_amp_en}, 33'h000000000);
    // All four commands at once; hardware reset clears counters
    wr(`CCDC_OFF_COMMAND, 32'h0000000F);
    rd(`CCDC_OFF_COMMAND, 32'h00000000);
    rd(`CCDC_OFF_MODE, 32'h00000000);
    rd(`CCDC_OFF_DCHG_CNT, 32'h00000000);
    chk({32'h00000000, o_reg_amp_en}, 33'h000000001);
    i_calib_ok <= 1'b1;
    rd(`CCDC_OFF_OFFSET, 32'h00700005);
    // Offset 5 with four-cycle steps: first added count 21 cycles after arming
    repeat (22) @(posedge i_clk_sys);
    rd(`CCDC_OFF_CHG_CNT, 32'h00000001);
    rd(`CCDC_OFF_DCHG_CNT, 32'h00000000);
    // Disarm, then arm towards discharge
    wr(`CCDC_OFF_OFFSET, 32'h00000005);
    wr(`CCDC_OFF_OFFSET, 32'h00200005);
    repeat (22) @(posedge i_clk_sys);
    rd(`CCDC_OFF_DCHG_CNT, 32'h00000001);
    repeat (4) @(posedge i_clk_sys);
    close_out();
  end

  // Watchdog: the run needs about 66500 cycles
  initial
  begin
    #320000;
    failures++;
    close_out();
  end
endmodule // ccdc_top_tb
